// file: hw/see_eeprom.sv
// Two-wire serial EEPROM target with 2048-byte array and programming timer.
// Assumes scl/sda arrive from the pins; serial logic runs on scl, the
// programming timer on core_clk; wp is an asynchronous pin.
`timescale 1ns/10ps
module see_eeprom (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic wp,
    output see_pkg::see_pin_t sda_pin,
    output logic busy
);
    import see_pkg::*;

    // Byte array: written by the core side, read by the serial side
    logic [7:0] mem [MEM_DEPTH];

    // Page buffer: written by the serial side, read by the core side
    logic [7:0] page_buf [16];

    // Serial-domain state, all of it clocked by scl
    typedef struct packed {
        see_state_t st; // Bus sequence state
        logic [3:0] bit_cnt; // Bits already taken in this word, 8 = ninth clock
        logic [7:0] shreg; // Incoming shift register
        logic [10:0] addr; // Persistent address counter
        logic rw; // Direction of current access
        logic ack_due; // Pull the line low on the ninth clock
        logic start_seen; // Copy of the start toggle already handled
        logic wpend; // Data bytes taken, waiting for the stop
        logic [6:0] page_row; // Row that the buffered bytes belong to
        logic [15:0] page_valid; // Buffered byte lanes
        logic [7:0] rd_byte; // Byte being shifted out
        logic [1:0] busy_sync; // Programming flag seen from the scl side
    } see_ser_t;

    // Core-domain state, all of it clocked by core_clk
    typedef struct packed {
        logic [2:0] stop_sync; // Stop toggle synchroniser plus edge stage
        logic [1:0] wp_sync; // Write-protect synchroniser
        logic [31:0] timer; // Programming countdown
        logic busy; // Programming in progress
        logic [6:0] commit_row; // Row captured at launch
        logic [15:0] commit_mask; // Lanes captured at launch
    } see_core_t;

    see_ser_t s, next_s;
    see_core_t c, next_c;

    // Start and stop toggles, clocked by the data line itself
    logic start_tgl;
    logic stop_tgl;

    // Serial-side helpers
    logic start_now; // A start is pending at this scl rise
    logic [7:0] word_in; // Word complete with the bit sampled now
    logic [10:0] rd_next; // Read address after an increment
    logic rd_bit; // Bit to present on the line
    logic buf_we; // Write the page buffer at this rise
    logic [3:0] buf_idx; // Lane of the page buffer write
    logic dev_match; // Address word carries our type pattern

    // Core-side helpers
    logic stop_evt; // Synchronised stop just arrived
    logic launch; // Start a programming cycle now
    logic commit; // Last cycle of programming

    // Low four bits wrap, page bits stay
    function automatic logic [10:0] page_inc(input logic [10:0] a);
        return {a[10:4], a[3:0] + 4'h1};
    endfunction

    // Whole-array increment, rolls from the last byte to the first
    function automatic logic [10:0] addr_inc(input logic [10:0] a);
        return a + 11'h001;
    endfunction

    // Falling data with the clock high marks a start
    // A toggle is used so the scl side sees it at its next rise,
    // even though scl falls before that rise.
    always_ff @(negedge sda_in or posedge rst) begin
        if (rst) begin
            start_tgl <= 1'b0;
        end else if (scl) begin
            start_tgl <= ~start_tgl;
        end
    end

    // Rising data with the clock high marks a stop
    // No scl edge follows a stop, so the core side picks it up
    always_ff @(posedge sda_in or posedge rst) begin
        if (rst) begin
            stop_tgl <= 1'b0;
        end else if (scl) begin
            stop_tgl <= ~stop_tgl;
        end
    end

    // Serial decode helpers
    assign start_now = (start_tgl != s.start_seen);
    assign word_in = {s.shreg[6:0], sda_in};
    assign rd_next = addr_inc(s.addr);
    assign rd_bit = s.rd_byte[3'h7 - s.bit_cnt[2:0]];
    assign dev_match = (word_in[7:4] == DEV_TYPE);

    // Serial next state: bits sampled at each rising scl
    always_comb begin
        next_s = s;
        buf_we = 1'b0;
        buf_idx = s.addr[3:0];
        // Busy only ever enters this domain through two stages
        next_s.busy_sync = {s.busy_sync[0], c.busy};
        if (start_now) begin
            // Every command begins here; this rise takes the first bit
            next_s.start_seen = start_tgl;
            next_s.st = SEE_DEV;
            next_s.bit_cnt = 4'h1;
            next_s.shreg = {7'h00, sda_in};
            next_s.ack_due = 1'b0;
            // A write not closed by a stop is dropped
            next_s.wpend = 1'b0;
        end else begin
            unique case (s.st)
                SEE_IDLE: begin
                    // Silent until the next start
                    next_s.bit_cnt = BIT_CNT_RST;
                    next_s.ack_due = 1'b0;
                end
                SEE_DEV, SEE_WADDR, SEE_WDATA: begin
                    if (s.bit_cnt == 4'h8) begin
                        // Ninth clock: the ack has been seen by the master
                        next_s.bit_cnt = 4'h0;
                        next_s.ack_due = 1'b0;
                    end else if (s.bit_cnt == 4'h7) begin
                        // Eighth bit lands: a full word is in
                        next_s.bit_cnt = 4'h8;
                        next_s.shreg = word_in;
                        if (s.st == SEE_DEV) begin
                            if (dev_match && !s.busy_sync[1]) begin
                                next_s.rw = word_in[0];
                                next_s.ack_due = 1'b1;
                                next_s.wpend = 1'b0;
                                next_s.page_valid = 16'h0000;
                                if (word_in[0]) begin
                                    // Current address read keeps the counter
                                    next_s.st = SEE_RDATA;
                                    next_s.rd_byte = mem[s.addr];
                                end else begin
                                    // Page bits become the top address bits
                                    next_s.addr[10:8] = word_in[3:1];
                                    next_s.st = SEE_WADDR;
                                end
                            end else begin
                                // Foreign type or busy: no ack, wait for start
                                next_s.st = SEE_IDLE;
                            end
                        end else if (s.st == SEE_WADDR) begin
                            next_s.addr[7:0] = word_in;
                            next_s.ack_due = 1'b1;
                            next_s.st = SEE_WDATA;
                        end else begin
                            // Data byte goes to its lane of the page buffer
                            buf_we = 1'b1;
                            next_s.page_valid[s.addr[3:0]] = 1'b1;
                            next_s.page_row = s.addr[10:4];
                            next_s.addr = page_inc(s.addr);
                            next_s.wpend = 1'b1;
                            // Acked even when protected
                            next_s.ack_due = 1'b1;
                        end
                    end else begin
                        // Shift in MSB first
                        next_s.shreg = {s.shreg[6:0], sda_in};
                        next_s.bit_cnt = s.bit_cnt + 4'h1;
                    end
                end
                SEE_RDATA: begin
                    if (s.bit_cnt == 4'h8) begin
                        // Ninth clock of the address word
                        next_s.bit_cnt = 4'h0;
                        next_s.ack_due = 1'b0;
                    end else if (s.bit_cnt == 4'h7) begin
                        // Last bit out; the master answers next
                        next_s.st = SEE_RACK;
                        next_s.bit_cnt = 4'h8;
                    end else begin
                        next_s.bit_cnt = s.bit_cnt + 4'h1;
                    end
                end
                SEE_RACK: begin
                    // The counter always moves past the byte just sent
                    next_s.addr = rd_next;
                    next_s.bit_cnt = 4'h0;
                    if (!sda_in) begin
                        // Master ack: next byte follows
                        next_s.st = SEE_RDATA;
                        next_s.rd_byte = mem[rd_next];
                    end else begin
                        // Master refusal ends the read
                        next_s.st = SEE_IDLE;
                    end
                end
                default: begin
                    next_s.st = SEE_IDLE;
                end
            endcase
        end
    end

    // Serial register and page buffer lane write
    // Reset is sampled here directly: it must be applied and released
    // while scl toggles slowly against core_clk, with at least one rising scl while it is held.
    always_ff @(posedge scl) begin
        if (rst) begin
            s <= '0;
            s.st <= SEE_IDLE;
            s.addr <= ADDR_RST;
            s.bit_cnt <= BIT_CNT_RST;
        end else begin
            s <= next_s;
            if (buf_we) begin
                page_buf[buf_idx] <= word_in;
            end
        end
    end

    // Output driver: the line changes only after falling scl
    always_ff @(negedge scl) begin
        if (rst) begin
            sda_pin <= '{sda_out: 1'b1, sda_oe_n: 1'b1};
        end else if (s.ack_due) begin
            // Acknowledge: pull the line low for the ninth clock
            sda_pin <= '{sda_out: 1'b0, sda_oe_n: 1'b0};
        end else if (s.st == SEE_RDATA && s.bit_cnt <= 4'h7) begin
            // Open drain: zeros are driven, ones are released
            sda_pin <= '{sda_out: rd_bit, sda_oe_n: rd_bit};
        end else begin
            // Released while receiving, idle or for the master ack
            sda_pin <= '{sda_out: 1'b1, sda_oe_n: 1'b1};
        end
    end

    // Core decode helpers
    assign stop_evt = (c.stop_sync[2] != c.stop_sync[1]);
    // Buffer, row and flag are read only after a stop, while the
    // serial side stands still, so they are stable when sampled here.
    assign launch = stop_evt && !c.busy && s.wpend && !c.wp_sync[1];
    assign commit = c.busy && (c.timer == 32'h0000_0001);

    // Core next state: synchronisers and programming timer
    always_comb begin
        next_c = c;
        next_c.wp_sync = {c.wp_sync[0], wp};
        next_c.stop_sync = {c.stop_sync[1:0], stop_tgl};
        if (launch) begin
            // Stop after data bytes starts a full-length cycle
            next_c.busy = 1'b1;
            next_c.timer = 32'(PROG_CYCLES);
            next_c.commit_row = s.page_row;
            next_c.commit_mask = s.page_valid;
        end else if (c.busy) begin
            // Count down; the last count ends programming
            next_c.timer = c.timer - 32'h0000_0001;
            if (commit) begin
                next_c.busy = 1'b0;
            end
        end
    end

    // Core registers; array updated in the last programming cycle
    // Protected stops never launch, so the array stays untouched
    always_ff @(posedge core_clk) begin
        if (rst) begin
            c <= '0;
            busy <= 1'b0;
        end else begin
            c <= next_c;
            busy <= next_c.busy;
            if (commit) begin
                for (int i = 0; i < 16; i++) begin
                    if (c.commit_mask[i]) begin
                        mem[{c.commit_row, 4'(i)}] <= page_buf[i];
                    end
                end
            end
        end
    end

    // Timer is loaded with the longest time as programming starts
    a_prog_load: assert property (@(posedge core_clk) disable iff (rst)
        $rose(c.busy) |-> c.timer == 32'(PROG_CYCLES))
        else $error("programming timer not loaded with longest time");

    // Timer steps down by one each cycle while programming
    a_timer_step: assert property (@(posedge core_clk) disable iff (rst)
        c.busy && c.timer != 32'h0000_0001 |=> c.busy && c.timer == $past(c.timer) - 32'h1)
        else $error("programming timer did not step");

    // Protected pin never starts programming
    a_wp_block: assert property (@(posedge core_clk) disable iff (rst)
        c.wp_sync[1] && !c.busy |=> !c.busy)
        else $error("programming started while write protected");

    // Busy output stands with the internal flag
    a_busy_out: assert property (@(posedge core_clk) disable iff (rst)
        c.busy |-> busy)
        else $error("busy output not high during programming");

    // Acknowledge is held for one clock only
    a_ack_once: assert property (@(posedge scl) disable iff (rst)
        s.ack_due |=> !s.ack_due)
        else $error("acknowledge held past the ninth clock");

    // Busy device gives no acknowledge to its address
    a_busy_nack: assert property (@(posedge scl) disable iff (rst)
        s.st == SEE_DEV && s.bit_cnt == 4'h7 && s.busy_sync[1] && !start_now
        |=> !s.ack_due)
        else $error("address acked while programming");

    // Write increments keep the page bits
    a_page_keep: assert property (@(posedge scl) disable iff (rst)
        s.st == SEE_WDATA && s.bit_cnt == 4'h7 && !start_now
        |=> s.addr[10:4] == $past(s.addr[10:4]))
        else $error("write increment left the page");

    // Read answer always moves the counter by one
    a_rd_step: assert property (@(posedge scl) disable iff (rst)
        s.st == SEE_RACK && !start_now |=> s.addr == $past(s.addr) + 11'h001)
        else $error("read counter did not advance by one");
endmodule

// file: hw/see_pkg.sv
// Package for the two-wire serial EEPROM target: constants, states and carriers.
// Assumes a 100 MHz core clock and a bus master that drives the serial clock.
package see_pkg;
    // Array geometry
    localparam int ADDR_W = 11;
    localparam int PAGE_LSB_W = 4;
    localparam int MEM_DEPTH = 2048;
    // Device-type pattern in the top nibble of the address word
    localparam logic [3:0] DEV_TYPE = 4'ha;
    // Core clock period in ns
    localparam int CLK_PERIOD_NS = 10;
    // Longest programming time, in ms as printed
    localparam int PROG_TIME_MS = 3;
    // Longest time rounds down to whole cycles
    localparam int PROG_CYCLES = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;
    // Reset values
    localparam logic [10:0] ADDR_RST = 11'h000;
    localparam logic [3:0] BIT_CNT_RST = 4'h0;

    // Bus-side sequence states
    typedef enum logic [2:0] {
        SEE_IDLE, SEE_DEV, SEE_WADDR, SEE_WDATA, SEE_RDATA, SEE_RACK
    } see_state_t;

    // Open-drain pin carrier
    typedef struct packed {
        logic sda_out;
        logic sda_oe_n;
    } see_pin_t;
endpackage

// file: sim/see_master.sv
// Two-wire bus master model: bus recovery, start, stop and byte transfers.
// Assumes a pulled-up data wire; scl stands high between frames, 64 ns period inside.
`timescale 1ns/10ps
module see_master (
    output logic scl,
    output logic sda_m,
    input wire logic sda
);
    // Both lines released at time zero
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // One clock: data moves mid-low, sampled mid-high
    task automatic bitx(input logic b, output logic r);
        #16 sda_m = b;
        #16 scl = 1'b1;
        #16 r = sda; // Well clear of both clock edges
        #16 scl = 1'b0;
    endtask
    // Nine clocks with data released, clock left high
    task automatic recover();
        repeat (9) begin
            #16 scl = 1'b0;
            #16 sda_m = 1'b1;
            #16 scl = 1'b1;
            #16;
        end
    endtask
    // Also serves as repeated start from a low clock
    task automatic start();
        #16 sda_m = 1'b1;
        #16 scl = 1'b1;
        #16 sda_m = 1'b0;
        #16 scl = 1'b0;
    endtask
    // Clock left high so it stands still between frames
    task automatic stop();
        #16 sda_m = 1'b0;
        #16 scl = 1'b1;
        #16 sda_m = 1'b1;
        #16;
    endtask
    // Eight bits MSB first, then the target's answer
    task automatic wbyte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) bitx(d[i], ack);
        bitx(1'b1, ack);
    endtask
    // Eight bits in, then our own ack or refusal
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(nack, r);
    endtask
endmodule

// file: sim/testbench.sv
// Self-checking bench: foreign addresses, page write with wrap, polling, reads, protect.
// Assumes the master model above; each programming cycle costs 3 ms of sim time.
`timescale 1ns/10ps
module testbench;
    import see_pkg::*;
    logic core_clk, rst, wp, scl, sda_m, sda; // Clock, reset, protect, wire
    see_pin_t sda_pin; // Target data pin
    logic busy; // Programming flag
    int errors, compares, seed, i; // Counters, seed, loop index
    logic [7:0] mem [16]; // Expected page contents
    logic [7:0] d, q; // Scratch bytes
    logic [3:0] hi; // Upper word-address nibble
    logic [2:0] pg; // Page-select bits
    logic a; // Ack level seen
    // Wired-AND with pull-up: a released pin reads high
    assign sda = sda_m & (sda_pin.sda_oe_n | sda_pin.sda_out);
    see_eeprom u_see_eeprom (.core_clk(core_clk), .rst(rst), .scl(scl), .sda_in(sda),
        .wp(wp), .sda_pin(sda_pin), .busy(busy));
    see_master u_see_master (.scl(scl), .sda_m(sda_m), .sda(sda));
    // 100 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Device address word for a page and direction
    function automatic logic [7:0] dev(input logic [2:0] p, input logic rd);
        return {4'ha, p, rd};
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // Send a byte and compare the answer level
    task automatic wb(input logic [7:0] b, input logic exp);
        u_see_master.wbyte(b, a);
        check("ack", 8'(a), 8'(exp));
    endtask
    // Bounded wait for the programming flag to drop
    task automatic wait_idle();
        i = 0;
        while (busy !== 1'b0 && i < 310000) begin
            @(posedge core_clk);
            i++;
        end
    endtask
    task automatic complete_run();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog: two programming cycles plus traffic
    initial begin
        #7000000;
        errors++;
        complete_run();
    end
    // Main sequence
    initial begin
        seed = 32;
        errors = 0;
        compares = 0;
        wp = 1'b0;
        rst = 1'b1;
        fork
            u_see_master.recover();
            repeat (10) @(posedge core_clk);
        join
        @(posedge core_clk) #1 rst = 1'b0;
        // Foreign device-type nibbles stay silent
        for (int k = 0; k < 4; k++) begin
            d = 8'($random(seed));
            if (d[7:4] == 4'ha) d[7:4] = 4'h5;
            u_see_master.start();
            wb(d, 1'b1);
            u_see_master.stop();
        end
        $display("test foreign address done");
        // Page write of 18 bytes from offset 14 wraps
        pg = 3'($random(seed));
        hi = 4'($random(seed));
        u_see_master.start();
        wb(dev(pg, 1'b0), 1'b0);
        wb({hi, 4'he}, 1'b0);
        for (int k = 0; k < 18; k++) begin
            d = 8'($random(seed));
            mem[4'he + 4'(k)] = d;
            wb(d, 1'b0);
        end
        u_see_master.stop();
        repeat (20) @(posedge core_clk);
        check("busy", 8'(busy), 8'h1);
        u_see_master.start();
        wb(dev(pg, 1'b0), 1'b1);
        u_see_master.stop();
        wait_idle();
        check("prog time", 8'(i <= 300000), 8'h1);
        $display("test page write done");
        // Poll acks, dummy write, then sequential and current reads
        u_see_master.start();
        wb(dev(pg, 1'b0), 1'b0);
        wb({hi, 4'h0}, 1'b0);
        u_see_master.start();
        wb(dev(pg, 1'b1), 1'b0);
        for (int k = 0; k < 15; k++) begin
            u_see_master.rbyte(k == 14, q);
            check("seq read", q, mem[k]);
        end
        u_see_master.stop();
        u_see_master.start();
        wb(dev(pg, 1'b1), 1'b0);
        u_see_master.rbyte(1'b1, q);
        check("current read", q, mem[15]);
        u_see_master.stop();
        $display("test reads done");
        // Protected write acks but leaves the byte alone
        @(posedge core_clk) #1 wp = 1'b1;
        u_see_master.start();
        wb(dev(pg, 1'b0), 1'b0);
        wb({hi, 4'h3}, 1'b0);
        wb(~mem[3], 1'b0);
        u_see_master.stop();
        wait_idle();
        @(posedge core_clk) #1 wp = 1'b0;
        u_see_master.start();
        wb(dev(pg, 1'b0), 1'b0);
        wb({hi, 4'h3}, 1'b0);
        u_see_master.start();
        wb(dev(pg, 1'b1), 1'b0);
        u_see_master.rbyte(1'b1, q);
        u_see_master.stop();
        check("protected byte", q, mem[3]);
        $display("test write protect done");
        complete_run();
    end
endmodule
